/* rtl/i2c_target_read_crc_stretch.sv */
// i2c target read engine with crc, clock stretching and ahb-lite registers
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "i2ct_params.svh"
// How it works
// [RQ1] Controller opens every read with start.
// [RQ2] First byte: own id, direction bit 0.
// [RQ3] Foreign id: ignore transaction, no acknowledge.
// [RQ4] Control word bytes, bit 23 set, acknowledged.
// [RQ5] Restart, id with read bit, acknowledged.
// [RQ6] 16/32-bit reads return addressed location, LSB first.
// [RQ7] Length code sets data byte count.
// [RQ8] 64-bit read: two words, second at +2.
// [RQ9] Controller acknowledges each returned byte.
// [RQ10] Check enable appends one crc byte.
// [RQ11] Read crc covers both ids, control, data.
// [RQ12] Crc-8, polynomial 0x07, seed 0xff.
// [RQ13] Write crc covers id, control, data.
// [RQ14] Write with wrong crc is discarded.
// [RQ15] Id match: stretch until start handled.
// [RQ16] Start behind unread byte: stretch for both.
// [RQ17] Second byte while holding full: stretch.
// [RQ18] Empty transmit buffer: stretch until filled.
// [RQ19] Stretching gives up after 5 ms.
// [RQ20] Control word MSB first, data LSB first.
// [RQ21] Controller ends each read with stop.
// [RQ22] Length 00/01/10 = 16/32/64 bits, 11 reserved.
// [RQ23] Control: direction, check, length, section, page, offset.
// [RQ24] Low 12 bits address the location.
// [RQ25] Timeout abandons transaction until next start.
module i2c_target_read_crc_stretch #(
	parameter int STRETCH_CYCLES = `STRETCH_LIMIT_NS / `SYS_CLK_PERIOD_NS
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);
	i2ct_pkg::state_t state;
	i2ct_pkg::bus_lines_t pins, lines;
	i2ct_pkg::status_t status;
	logic scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det;
	logic ctrl_en;
	logic [6:0] target_id;
	logic [23:0] cw;
	logic cw_valid, read_phase, addr_ack, ack_ok, mack_ok, loaded, deferred;
	logic start_pend, rx_full, tx_full, wr_active, crc_match;
	logic wr_done, wr_bad, timeout_flag;
	logic [7:0] shreg, rx_data, tx_data, byte_in, crc;
	logic [3:0] bit_cnt, byte_idx, n_data, n_total;
	logic [CNT_W-1:0] stretch_cnt;
	logic byte_done, id_match, rx_accept, crc_byte, crc_now, tx_load, timeout_hit;
	logic crc_init, crc_feed;
	logic [7:0] crc_in;
	logic next_scl_oe, next_sda_oe, wr_eval, wr_good;
	logic dp_valid, dp_write, rd_wait, reg_wr, rx_pop;
	logic [7:0] dp_addr;

	assign pins = '{scl: scl_in, sda: sda_in};
	i2ct_sync #(.WIDTH(2)) u_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.d_in(pins),
		.q_out(lines)
	);

	// bus edges and conditions from the synchronised lines
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= lines.scl;
			sda_q <= lines.sda;
		end
	end
	assign scl_rise = lines.scl & ~scl_q;
	assign scl_fall = ~lines.scl & scl_q;
	assign start_det = lines.scl & scl_q & sda_q & ~lines.sda;
	assign stop_det = lines.scl & scl_q & ~sda_q & lines.sda;

	always_comb begin
		case (cw[`CW_LEN_HI:`CW_LEN_LO])
			`LEN_16: n_data = `LEN_16_BYTES; // [RQ22]
			`LEN_32: n_data = `LEN_32_BYTES;
			`LEN_64: n_data = `LEN_64_BYTES; // [RQ8]
			default: n_data = 4'h0;
		endcase
	end
	assign n_total = n_data + {3'h0, cw[`CW_CRC_BIT]}; // [RQ10]

	assign byte_in = {shreg[6:0], lines.sda};
	assign byte_done = scl_rise && bit_cnt == 4'h7
		&& (state == i2ct_pkg::st_addr || state == i2ct_pkg::st_rx);
	assign id_match = ctrl_en && byte_in[7:1] == target_id; // [RQ3]
	// control bytes always taken; write data up to length, plus crc byte when check is set
	assign rx_accept = byte_idx < `CW_BYTES
		|| (!cw[`CW_DIR_BIT] && n_data != 4'h0 && byte_idx < `CW_BYTES + n_total); // [RQ4]
	assign crc_byte = cw[`CW_CRC_BIT] && byte_idx == `CW_BYTES + n_data;
	assign crc_now = byte_idx == n_data;
	assign tx_load = state == i2ct_pkg::st_tx && !loaded && !crc_now && tx_full;
	assign timeout_hit = scl_oe && stretch_cnt == CNT_W'(STRETCH_CYCLES - 1); // [RQ19]

	// crc: seeded by write id, fed by both ids, control and data bytes
	always_comb begin
		crc_init = byte_done && state == i2ct_pkg::st_addr && id_match && !byte_in[0]; // [RQ12]
		crc_feed = 1'b0;
		crc_in = byte_in;
		if (byte_done && state == i2ct_pkg::st_addr) begin
			crc_feed = id_match && (!byte_in[0] || cw_valid); // [RQ11]
		end else if (byte_done) begin
			crc_feed = rx_accept && !crc_byte; // [RQ13]
		end else if (tx_load) begin
			crc_feed = 1'b1; // [RQ11]
			crc_in = tx_data;
		end
	end
	i2ct_crc8 u_crc (
		.sys_clk(sys_clk),
		.srst(srst),
		.init(crc_init),
		.valid(crc_feed),
		.data(crc_in),
		.crc(crc)
	);

	// bus sequencing
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= i2ct_pkg::st_idle;
			bit_cnt <= 4'h0;
		end else if (timeout_hit) begin
			state <= i2ct_pkg::st_ignore; // [RQ25]
		end else if (start_det) begin
			state <= i2ct_pkg::st_addr; // [RQ1]
			bit_cnt <= 4'h0;
		end else if (stop_det) begin
			state <= i2ct_pkg::st_idle; // [RQ21]
		end else begin
			case (state)
				i2ct_pkg::st_addr, i2ct_pkg::st_rx: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end
					if (scl_fall && bit_cnt == 4'h8) begin
						state <= ack_ok ? i2ct_pkg::st_ack : i2ct_pkg::st_ignore; // [RQ3]
					end
				end
				i2ct_pkg::st_ack: begin
					if (scl_fall) begin
						state <= read_phase ? i2ct_pkg::st_tx : i2ct_pkg::st_rx;
						bit_cnt <= 4'h0;
					end
				end
				i2ct_pkg::st_tx: begin
					if (scl_fall && loaded) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == 4'h7) begin
							state <= i2ct_pkg::st_mack;
						end
					end
				end
				i2ct_pkg::st_mack: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (mack_ok && byte_idx < n_total) begin
							state <= i2ct_pkg::st_tx; // [RQ9]
						end else begin
							state <= i2ct_pkg::st_ignore; // [RQ7]
						end
					end
				end
				i2ct_pkg::st_idle, i2ct_pkg::st_ignore: begin
					bit_cnt <= 4'h0;
				end
				default: begin
					state <= i2ct_pkg::st_idle;
				end
			endcase
		end
	end

	// shift register; transmit bytes leave msb first
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			shreg <= 8'h00;
			loaded <= 1'b0;
		end else if (state != i2ct_pkg::st_tx) begin
			loaded <= 1'b0;
			if (scl_rise && (state == i2ct_pkg::st_addr || state == i2ct_pkg::st_rx)) begin
				shreg <= byte_in;
			end
		end else if (!loaded) begin
			if (crc_now) begin
				shreg <= crc; // [RQ10]
				loaded <= 1'b1;
			end else if (tx_full) begin
				shreg <= tx_data; // [RQ6]
				loaded <= 1'b1;
			end
		end else if (scl_fall) begin
			shreg <= {shreg[6:0], 1'b0};
		end
	end

	// transaction tracking
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cw <= 24'h000000;
			cw_valid <= 1'b0;
			read_phase <= 1'b0;
			addr_ack <= 1'b0;
			ack_ok <= 1'b0;
			mack_ok <= 1'b0;
			byte_idx <= 4'h0;
			start_pend <= 1'b0;
			wr_active <= 1'b0;
			crc_match <= 1'b0;
		end else if (timeout_hit) begin
			start_pend <= 1'b0; // [RQ25]
			wr_active <= 1'b0;
		end else begin
			if (start_det || stop_det) begin
				wr_active <= 1'b0;
			end
			if (reg_wr && dp_addr == `REG_STATUS && hwdata[`ST_START_BIT]) begin
				start_pend <= 1'b0;
			end
			if (byte_done && state == i2ct_pkg::st_addr) begin
				addr_ack <= 1'b1;
				byte_idx <= 4'h0;
				read_phase <= byte_in[0];
				ack_ok <= id_match && (!byte_in[0] || cw_valid); // [RQ2] [RQ5]
				if (id_match && (!byte_in[0] || cw_valid)) begin
					start_pend <= 1'b1; // [RQ15]
				end
				if (id_match && !byte_in[0]) begin
					cw_valid <= 1'b0;
				end
			end else if (byte_done) begin
				addr_ack <= 1'b0;
				ack_ok <= rx_accept;
				if (rx_accept) begin
					byte_idx <= byte_idx + 4'h1;
				end
				if (byte_idx < `CW_BYTES) begin
					cw <= {cw[15:0], byte_in}; // [RQ20] [RQ23]
				end
				if (byte_idx == 4'h2) begin
					cw_valid <= cw[15];
					wr_active <= !cw[15];
				end
				if (crc_byte) begin
					crc_match <= byte_in == crc; // [RQ14]
				end
			end
			if (state == i2ct_pkg::st_mack && scl_rise) begin
				mack_ok <= !lines.sda;
				byte_idx <= byte_idx + 4'h1;
			end
		end
	end

	// receive holding register; a second byte waits in the shifter
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_full <= 1'b0;
			rx_data <= 8'h00;
			deferred <= 1'b0;
		end else begin
			if (rx_pop) begin
				rx_full <= 1'b0;
			end
			if (timeout_hit) begin
				deferred <= 1'b0;
			end else if (byte_done && state == i2ct_pkg::st_rx && rx_accept) begin
				if (rx_full && !rx_pop) begin
					deferred <= 1'b1; // [RQ17]
				end else begin
					rx_data <= byte_in;
					rx_full <= 1'b1;
				end
			end else if (deferred && (!rx_full || rx_pop)) begin
				rx_data <= shreg;
				rx_full <= 1'b1;
				deferred <= 1'b0;
			end
		end
	end

	// transmit holding register; a new write wins over a load
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_full <= 1'b0;
			tx_data <= 8'h00;
		end else if (reg_wr && dp_addr == `REG_TXDATA) begin
			tx_full <= 1'b1;
			tx_data <= hwdata[7:0];
		end else if (tx_load || timeout_hit) begin
			tx_full <= 1'b0;
		end
	end

	// write outcome and sticky flags; hardware set wins over clear
	assign wr_eval = wr_active && (start_det || stop_det);
	assign wr_good = byte_idx == `CW_BYTES + n_total && (!cw[`CW_CRC_BIT] || crc_match);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_done <= 1'b0;
			wr_bad <= 1'b0;
			timeout_flag <= 1'b0;
		end else begin
			if (reg_wr && dp_addr == `REG_STATUS) begin
				wr_done <= wr_done & ~hwdata[`ST_WR_DONE_BIT];
				wr_bad <= wr_bad & ~hwdata[`ST_WR_BAD_BIT];
				timeout_flag <= timeout_flag & ~hwdata[`ST_TIMEOUT_BIT];
			end
			if (wr_eval && wr_good) begin
				wr_done <= 1'b1;
			end
			if (wr_eval && !wr_good) begin
				wr_bad <= 1'b1; // [RQ14]
			end
			if (timeout_hit) begin
				timeout_flag <= 1'b1;
			end
		end
	end

	// line drivers
	always_comb begin
		next_scl_oe = !timeout_hit && ((state == i2ct_pkg::st_ack
			&& (deferred || (addr_ack && (start_pend || rx_full)))) // [RQ15] [RQ16] [RQ17]
			|| (state == i2ct_pkg::st_tx && !loaded)); // [RQ18]
		next_sda_oe = !timeout_hit && ((state == i2ct_pkg::st_ack && ack_ok)
			|| (state == i2ct_pkg::st_tx && loaded && !shreg[7]));
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			stretch_cnt <= '0;
		end else begin
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			stretch_cnt <= scl_oe ? stretch_cnt + CNT_W'(1) : '0; // [RQ19]
		end
	end
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// ahb-lite slave: writes zero-wait, reads one wait state
	assign hresp = 1'b0;
	assign hreadyout = !(dp_valid && !dp_write && !rd_wait);
	assign reg_wr = dp_valid && dp_write;
	assign rx_pop = dp_valid && !dp_write && !rd_wait && dp_addr == `REG_RXDATA;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_valid <= hsel && htrans[1];
			dp_write <= hwrite;
			dp_addr <= haddr[7:0];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_en <= 1'(`CTRL_RST & 8'h01);
			target_id <= 7'h00;
		end else if (reg_wr && dp_addr == `REG_CTRL) begin
			ctrl_en <= hwdata[0];
			target_id <= hwdata[7:1];
		end
	end
	always_comb begin
		status = '0;
		status.start_pend = start_pend;
		status.rx_full = rx_full;
		status.tx_need = state == i2ct_pkg::st_tx && !loaded && !crc_now && !tx_full;
		status.tx_full = tx_full;
		status.wr_done = wr_done;
		status.wr_bad = wr_bad;
		status.timeout = timeout_flag;
		status.read_phase = read_phase;
		status.byte_idx = byte_idx;
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_wait <= 1'b0;
			hrdata <= 32'h00000000;
		end else if (dp_valid && !dp_write && !rd_wait) begin
			rd_wait <= 1'b1;
			case (dp_addr)
				`REG_CTRL: hrdata <= {24'h000000, target_id, ctrl_en};
				`REG_STATUS: hrdata <= status;
				`REG_RXDATA: hrdata <= {24'h000000, rx_data};
				`REG_CWORD: hrdata <= {7'h00, cw_valid, cw};
				`REG_ADDR2: hrdata <= {20'h00000, cw[`CW_OFF_HI:0] + `ADDR2_STEP}; // [RQ8] [RQ24]
				default: hrdata <= 32'h00000000;
			endcase
		end else begin
			rd_wait <= 1'b0;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_stretch_full;
		scl_oe [*2];
	endsequence
	a_foreign_id_silent: assert property ( // [RQ3]
		byte_done && state == i2ct_pkg::st_addr && !id_match |=> !ack_ok ##1 !sda_oe [*4])
		else $error("foreign id got an acknowledge");
	a_start_stretch: assert property ( // [RQ15]
		state == i2ct_pkg::st_ack && addr_ack && start_pend && !timeout_hit |=> scl_oe)
		else $error("pending start not stretched");
	a_rx_full_stretch: assert property ( // [RQ17]
		state == i2ct_pkg::st_ack && deferred && rx_full && !rx_pop && !timeout_hit
		|=> s_stretch_full or !deferred or timeout_flag or timeout_hit)
		else $error("full holding register not stretched");
	a_tx_empty_stretch: assert property ( // [RQ18]
		state == i2ct_pkg::st_tx && !loaded && !tx_full && !crc_now && !timeout_hit |=> scl_oe)
		else $error("empty transmit buffer not stretched");
	a_timeout_release: assert property ( // [RQ19]
		timeout_hit |=> !scl_oe && !sda_oe && state == i2ct_pkg::st_ignore && timeout_flag)
		else $error("stretch did not end on timeout");
	a_stretch_bound: assert property ( // [RQ19]
		scl_oe |-> stretch_cnt < CNT_W'(STRETCH_CYCLES))
		else $error("stretch ran past its limit");
	a_tx_byte_load: assert property ( // [RQ6]
		tx_load && !timeout_hit |=> loaded && shreg == $past(tx_data) && !sda_oe
		##1 sda_oe == !shreg[7])
		else $error("transmit byte not loaded as written");
	a_length_stop: assert property ( // [RQ7]
		state == i2ct_pkg::st_mack && scl_fall && !start_det && !stop_det && !timeout_hit
		&& byte_idx >= n_total |=> state == i2ct_pkg::st_ignore)
		else $error("more bytes sent than length allows");
	a_ctrl_ack: assert property ( // [RQ4]
		byte_done && state == i2ct_pkg::st_rx && byte_idx < `CW_BYTES |=> ack_ok)
		else $error("control byte not acknowledged");
	a_bad_crc_drop: assert property ( // [RQ14]
		wr_eval && cw[`CW_CRC_BIT] && !crc_match |=> wr_bad && !$rose(wr_done))
		else $error("write with wrong crc not discarded");
endmodule : i2c_target_read_crc_stretch

/* rtl/i2ct_params.svh */
// constants for the i2c target read engine
`ifndef I2CT_PARAMS_SVH
`define I2CT_PARAMS_SVH
`define SYS_CLK_PERIOD_NS 25
`define STRETCH_LIMIT_NS 5000000
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RXDATA 8'h08
`define REG_TXDATA 8'h0c
`define REG_CWORD 8'h10
`define REG_ADDR2 8'h14
`define CTRL_RST 8'h00
`define CRC_INIT 8'hff
`define CRC_POLY 8'h07
`define ADDR2_STEP 12'h002
`define CW_DIR_BIT 23
`define CW_CRC_BIT 22
`define CW_LEN_HI 21
`define CW_LEN_LO 20
`define CW_OFF_HI 11
`define LEN_16 2'b00
`define LEN_32 2'b01
`define LEN_64 2'b10
`define LEN_16_BYTES 4'h2
`define LEN_32_BYTES 4'h4
`define LEN_64_BYTES 4'h8
`define CW_BYTES 4'h3
`define ST_START_BIT 0
`define ST_WR_DONE_BIT 4
`define ST_WR_BAD_BIT 5
`define ST_TIMEOUT_BIT 6
`endif

/* rtl/i2ct_pkg.sv */
// types shared by the i2c target read engine
package i2ct_pkg;
	typedef enum logic [2:0] {st_idle, st_addr, st_rx, st_ack, st_tx, st_mack, st_ignore} state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_t;
	typedef struct packed {
		logic [19:0] zero;
		logic [3:0] byte_idx;
		logic read_phase;
		logic timeout;
		logic wr_bad;
		logic wr_done;
		logic tx_full;
		logic tx_need;
		logic rx_full;
		logic start_pend;
	} status_t;
endpackage : i2ct_pkg

/* rtl/i2ct_sync.sv */
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
module i2ct_sync #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta;
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				meta[i] <= 1'b1;
				q_out[i] <= 1'b1;
			end else begin
				meta[i] <= d_in[i];
				q_out[i] <= meta[i];
			end
		end
	end
endmodule : i2ct_sync

/* rtl/i2ct_crc8.sv */
// byte-wide crc-8 engine
`timescale 1ns/1ps
`include "i2ct_params.svh"
module i2ct_crc8 (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic init,
	input wire logic valid,
	input wire logic [7:0] data,
	output logic [7:0] crc
);
	logic [7:0] next_crc;
	always_comb begin
		next_crc = (init ? `CRC_INIT : crc) ^ data;
		for (int i = 0; i < 8; i++) begin
			next_crc = next_crc[7] ? ({next_crc[6:0], 1'b0} ^ `CRC_POLY) : {next_crc[6:0], 1'b0};
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			crc <= `CRC_INIT;
		end else if (valid) begin
			crc <= next_crc;
		end else if (init) begin
			crc <= `CRC_INIT;
		end
	end
	a_crc_zero_byte: assert property (@(posedge sys_clk) disable iff (srst) // [RQ12]
		init && valid && data == 8'h00 |=> crc == 8'hf3)
		else $error("crc of zero byte from seed is wrong");
	a_crc_seed_value: assert property (@(posedge sys_clk) disable iff (srst) // [RQ12]
		init && !valid |=> crc == 8'hff)
		else $error("crc seed is not ff");
endmodule : i2ct_crc8

/* verif/i2ct_ctrl_model.sv */
// i2c bus controller model on open-drain scl and sda
`timescale 1ns/1ps
module i2ct_ctrl_model (
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	int stretch_ns = 0;
	initial begin
		scl_oe = 1'h0;
		sda_oe = 1'h0;
	end
	// release scl, then wait out a stretch by the target of up to 200000 ns
	task automatic rise();
		stretch_ns = 0;
		scl_oe = 1'h0;
		#1;
		while (scl !== 1'h1 && stretch_ns < 200000) begin
			#5;
			stretch_ns += 5;
		end
	endtask : rise
	// start or repeated start, scl left low
	task automatic start();
		sda_oe = 1'h0;
		#50;
		rise();
		#50;
		sda_oe = 1'h1;
		#100;
		scl_oe = 1'h1;
		#50;
	endtask : start
	task automatic stop();
		sda_oe = 1'h1;
		#50;
		rise();
		#50;
		sda_oe = 1'h0;
		#100;
	endtask : stop
	// nine bits, msb first; b9 high releases sda in the ack slot
	task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
		output logic s9);
		logic [8:0] o;
		o = {tx, b9};
		for (int i = 8; i >= 0; i--) begin
			sda_oe = ~o[i];
			#50;
			rise();
			#50;
			o[i] = sda;
			#50;
			scl_oe = 1'h1;
			#50;
		end
		sda_oe = 1'h0;
		rx = o[8:1];
		s9 = o[0];
	endtask : xfer
endmodule : i2ct_ctrl_model

/* verif/i2c_target_read_crc_stretch_bench.sv */
// self-checking bench for the i2c target read engine
`timescale 1ns/1ps
module i2c_target_read_crc_stretch_bench;
	localparam int stretch_cycles = 200;
	logic sys_clk = 1'h0;
	logic srst = 1'h1;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
	wire logic scl = ~(scl_oe | m_scl_oe);
	wire logic sda = ~(sda_oe | m_sda_oe);
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	logic sw_on = 1'h0;
	logic sw_busy = 1'h0;
	int sw_lag = 0;
	i2ct_pkg::status_t sw_st;
	logic [31:0] sw_v;
	logic [7:0] rx_q[$];
	logic [7:0] tx_q[$];
	logic [6:0] own_id;
	logic [7:0] got;
	logic s9;
	logic [31:0] v;
	always #12.5 sys_clk = ~sys_clk;
	i2c_target_read_crc_stretch #(.STRETCH_CYCLES(stretch_cycles)) dut (.sys_clk(sys_clk),
		.srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
	i2ct_ctrl_model ctl (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'h0} ^ 8'h07 : {c[6:0], 1'h0};
		return c;
	endfunction : crc8
	// single word transfer; entered right after a rising edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'h1) @(posedge sys_clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hreadyout !== 1'h1) @(posedge sys_clk);
		rd = hrdata;
		chk("bus response", {31'h0, hresp}, 32'h0);
	endtask : ahb
	task automatic send(input logic [7:0] b, inout logic [7:0] crc);
		ctl.xfer(b, 1'h1, got, s9);
		chk("target ack", s9, 1'h0);
		crc = crc8(crc, b);
	endtask : send
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			chk("run time limit", 32'h0, 32'h1);
			conclude();
		end
	end
	// firmware: pops bytes, handles starts, refills transmit data
	always @(posedge sys_clk) begin
		if (sw_on) begin
			sw_busy = 1'h1;
			// slow firmware lets received bytes pile up
			repeat (sw_lag) @(posedge sys_clk);
			ahb(1'h0, 8'h04, 32'h0, sw_v);
			sw_st = sw_v;
			if (sw_st.rx_full) begin
				ahb(1'h0, 8'h08, 32'h0, sw_v);
				rx_q.push_back(sw_v[7:0]);
			end else if (sw_st.start_pend) begin
				ahb(1'h1, 8'h04, 32'h1, sw_v);
			end else if (sw_st.tx_need && !sw_st.tx_full && tx_q.size() > 0) begin
				ahb(1'h1, 8'h0c, {24'h0, tx_q.pop_front()}, sw_v);
			end
			sw_busy = 1'h0;
		end
	end
	task automatic txn(input logic rd, input logic [1:0] len, input logic ce, input logic rs,
		input logic bad);
		logic [23:0] cw;
		logic [7:0] crc;
		logic [7:0] dq[$];
		int k;
		cw = {rd, ce, len, 8'h00, 12'($urandom)};
		crc = 8'hff;
		rx_q.delete();
		for (int i = 0; i < (2 << len); i++) dq.push_back(8'($urandom));
		if (rd) tx_q = dq;
		sw_on = 1'h1;
		ctl.start();
		send({own_id, 1'h0}, crc);
		for (int i = 2; i >= 0; i--) send(cw[i*8+:8], crc);
		if (rd) begin
			if (!rs) ctl.stop();
			ctl.start();
			send({own_id, 1'h1}, crc);
			foreach (dq[i]) begin
				ctl.xfer(8'hff, 1'h0, got, s9);
				chk("read byte", got, dq[i]);
				crc = crc8(crc, dq[i]);
			end
			if (ce) begin
				ctl.xfer(8'hff, 1'h0, got, s9);
				chk("read crc", got, crc);
			end
		end else begin
			foreach (dq[i]) send(dq[i], crc);
			send(crc ^ {7'h0, bad}, crc);
		end
		ctl.stop();
		k = 0;
		while (sw_st.rx_full !== 1'h0 && k < 100) begin
			@(posedge sys_clk);
			k++;
		end
		sw_on = 1'h0;
		@(posedge sys_clk);
		while (sw_busy) @(posedge sys_clk);
		for (int i = 0; i < 3; i++) chk("control byte", rx_q[i], cw[(2-i)*8+:8]);
		ahb(1'h0, 8'h14, 32'h0, v);
		chk("second address", v, {20'h0, cw[11:0] + 12'h002});
		ahb(1'h0, 8'h04, 32'h0, v);
		if (!rd) chk("write outcome", v[5:4], bad ? 2'h2 : 2'h1);
		ahb(1'h1, 8'h04, 32'h70, v);
		$display("transfer rd=%0d len=%0d crc=%0d done", rd, len, ce);
	endtask : txn
	initial begin
		void'($urandom(45359));
		repeat (16) @(posedge sys_clk);
		srst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		ahb(1'h0, 8'h00, 32'h0, v);
		chk("control reset value", v, 32'h0);
		ahb(1'h0, 8'h20, 32'h0, v);
		chk("unmapped read", v, 32'h0);
		own_id = 7'($urandom);
		ahb(1'h1, 8'h00, {24'h0, own_id, 1'h1}, v);
		ctl.start();
		ctl.xfer({own_id ^ 7'h01, 1'h0}, 1'h1, got, s9);
		chk("foreign id ack", s9, 1'h1);
		ctl.stop();
		@(posedge sys_clk);
		ahb(1'h0, 8'h04, 32'h0, v);
		chk("foreign id start", v[0], 1'h0);
		$display("foreign id test done");
		for (int l = 0; l < 3; l++) begin
			txn(1'h1, l[1:0], 1'h1, l[0], 1'h0);
			txn(1'h1, l[1:0], 1'h0, ~l[0], 1'h0);
			txn(1'h0, l[1:0], 1'h1, 1'h0, l[0]);
		end
		ctl.start();
		ctl.xfer({own_id, 1'h0}, 1'h1, got, s9);
		chk("stretch limit", ctl.stretch_ns > stretch_cycles * 25 - 500
			&& ctl.stretch_ns < stretch_cycles * 25 + 150, 1'h1);
		@(posedge sys_clk);
		ahb(1'h0, 8'h04, 32'h0, v);
		chk("timeout flags", {v[6], v[0]}, 2'h2);
		ahb(1'h1, 8'h04, 32'h70, v);
		ctl.xfer(8'hd0, 1'h1, got, s9);
		chk("ignored after timeout", s9, 1'h1);
		ctl.stop();
		$display("stretch timeout test done");
		sw_lag = 100;
		txn(1'h1, 2'h1, 1'h1, 1'h1, 1'h0);
		chk("open drain level", {scl_out, sda_out}, 2'h0);
		conclude();
	end
endmodule : i2c_target_read_crc_stretch_bench
